//--- verilog/iomdr_diag_record.sv
`timescale 1ns/1ps
module iomdr_diag_record
  import iomdr_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int TICKS = TICK_CYCLES
)(
  input wire logic core_clk, // Module clock
  input wire logic srst, // Synchronous reset, active high
  input wire iomdr_module_fault_type moduleFault, // Module fault levels
  input wire iomdr_chan_fault_type [NUM_CH-1:0] chanFault, // Channel fault levels
  input wire logic readReq, // Read strobe, one cycle
  input wire iomdr_read_req_type readAddr, // Record set and byte index
  output logic readValid, // Answer strobe, one cycle
  output logic readRefused, // Answer is a refusal
  output logic [7:0] readData, // Record byte
  output logic [NUM_CH-1:0] chanErrorLed, // Channel error indicators
  output logic moduleErrorLed // Module error indicator
);

  logic [STAMP_WIDTH-1:0] usCount;
  logic [7:0] moduleFaultReg;
  logic [7:0] moduleFaultNext;
  logic [7:0] internalFaultReg;
  logic [7:0] internalFaultNext;
  logic [7:0] summaryReg;
  logic [7:0] summaryNext;
  logic [7:0] chanByteReg [NUM_CH];
  logic [7:0] chanByteNext [NUM_CH];
  logic [NUM_CH-1:0] chanAny;
  logic [STAMP_WIDTH-1:0] stampReg;
  logic [STAMP_WIDTH-1:0] stampNext;
  logic newEvent;
  logic [NUM_CH-1:0] chanNew;
  logic [NUM_CH-1:0] ledReg;
  logic [NUM_CH-1:0] ledNext;
  logic moduleLedReg;
  logic moduleLedNext;
  logic validReg;
  logic validNext;
  logic refusedReg;
  logic refusedNext;
  logic [7:0] dataReg;
  logic [7:0] dataNext;
  logic [7:0] classInfo;
  logic [7:0] kindByte;

  ////////////////////////////////////////////////////////////////////////////
  // Microsecond timebase
  // Reset stands in for power-on: the count restarts from zero with it

  iomdr_us_timer #(
    .TICKS(TICKS)
  ) usTimer (
    .core_clk(core_clk),
    .srst(srst),
    .usCount(usCount)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel fault bytes; bytes track live fault levels

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : gChan
      // Byte built from live fault levels; reserved bits stay zero,
      // so a dropped input clears its bit on the next edge
      always_comb
      begin
        chanByteNext[ch] = BYTE_RESET;
        chanByteNext[ch][CF_PARAM_BIT] = chanFault[ch].paramError;
        chanByteNext[ch][CF_UNDERFLOW_BIT] = chanFault[ch].underflow;
        chanByteNext[ch][CF_OVERFLOW_BIT] = chanFault[ch].overflow;
      end

      // One byte register per channel, cleared by reset
      always_ff @(posedge core_clk)
      begin
        if (srst)
        begin
          chanByteReg[ch] <= BYTE_RESET;
        end
        else
        begin
          chanByteReg[ch] <= chanByteNext[ch];
        end
      end

      // Summary is derived from the next channel byte so both update together
      assign chanAny[ch] = |chanByteNext[ch];
      assign chanNew[ch] = |(chanByteNext[ch] & ~chanByteReg[ch]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Module-level fault bytes and channel group summary
  // The channel flag and the summary come from the same next values, so a
  // read never finds one of them set without the other

  always_comb
  begin
    moduleFaultNext = BYTE_RESET;
    moduleFaultNext[MF_FAILURE_BIT] = moduleFault.failure;
    moduleFaultNext[MF_INTERNAL_BIT] = moduleFault.internal;
    moduleFaultNext[MF_EXTERNAL_BIT] = moduleFault.external;
    moduleFaultNext[MF_CHANNEL_BIT] = |chanAny;
    moduleFaultNext[MF_AUX_SUPPLY_BIT] = moduleFault.auxSupplyMissing;
    moduleFaultNext[MF_PARAM_BIT] = moduleFault.paramError;
    internalFaultNext = BYTE_RESET;
    internalFaultNext[IF_BUF_OVERFLOW_BIT] = moduleFault.bufOverflow;
    internalFaultNext[IF_COMM_BIT] = moduleFault.commError;
    summaryNext = BYTE_RESET;
    summaryNext[NUM_CH-1:0] = chanAny;
  end

  // Fault byte registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      moduleFaultReg <= BYTE_RESET;
      internalFaultReg <= BYTE_RESET;
      summaryReg <= BYTE_RESET;
    end
    else
    begin
      moduleFaultReg <= moduleFaultNext;
      internalFaultReg <= internalFaultNext;
      summaryReg <= summaryNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timestamp: a diagnostic event is any fault bit newly set this cycle.
  // Clearing faults does not restamp, so the field keeps the last onset.
  // A fault that drops and comes back counts as a new onset and restamps.

  assign newEvent = (|(moduleFaultNext & ~moduleFaultReg))
    | (|(internalFaultNext & ~internalFaultReg))
    | (|chanNew);

  // The count taken is the one standing on the edge that registers the fault
  always_comb
  begin
    stampNext = stampReg;
    if (newEvent)
    begin
      stampNext = usCount;
    end
  end

  // Stamp register, cleared along with the timer
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stampReg <= '0;
    end
    else
    begin
      stampReg <= stampNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicators follow the recorded faults; no interrupt is raised at all

  always_comb
  begin
    ledNext = chanAny;
    moduleLedNext = |moduleFaultNext | (|internalFaultNext);
  end

  // Registered so indicators change on the same edge as the record bytes
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ledReg <= '0;
      moduleLedReg <= 1'b0;
    end
    else
    begin
      ledReg <= ledNext;
      moduleLedReg <= moduleLedNext;
    end
  end

  assign chanErrorLed = ledReg;
  assign moduleErrorLed = moduleLedReg;

  ////////////////////////////////////////////////////////////////////////////
  // Constant descriptor bytes

  // The record always carries per-channel bytes, so the flag stays set
  assign classInfo = {3'b000, 1'b1, CLASS_ANALOG};
  assign kindByte = {1'b0, KIND_ANALOG_IN};

  ////////////////////////////////////////////////////////////////////////////
  // Record read port. Set 00h is cut to the header, set 01h gives the whole record; other sets are refused.

  // Byte decode; spare and reserved places read as zero.
  // Limitation: timestamp bytes are read one at a time with no snapshot,
  // so a reader wanting a coherent value reads all four back to back.
  function automatic logic [7:0] recordByte(input logic [4:0] idx);
    logic [7:0] b;
    logic [4:0] rel;
    b = BYTE_RESET;
    rel = 5'h00;
    if (idx == OFS_MODULE_FAULT)
    begin
      b = moduleFaultReg;
    end
    else if (idx == OFS_CLASS_INFO)
    begin
      b = classInfo;
    end
    else if (idx == OFS_SPARE_FAULT)
    begin
      b = BYTE_RESET;
    end
    else if (idx == OFS_INTERNAL_FAULT)
    begin
      b = internalFaultReg;
    end
    else if (idx == OFS_CHANNEL_KIND)
    begin
      b = kindByte;
    end
    else if (idx == OFS_DIAG_BITS)
    begin
      b = DIAG_BITS_VALUE;
    end
    else if (idx == OFS_CHANNEL_COUNT)
    begin
      b = CHANNEL_COUNT_VALUE;
    end
    else if (idx == OFS_GROUP_SUMMARY)
    begin
      b = summaryReg;
    end
    else if (idx >= OFS_CHANNEL_FAULT && idx < OFS_UNUSED_FAULT)
    begin
      rel = idx - OFS_CHANNEL_FAULT;
      if (rel < 5'(NUM_CH))
      begin
        b = chanByteReg[rel[1:0]];
      end
    end
    else if (idx >= OFS_TIMESTAMP)
    begin
      // Least significant byte first
      rel = idx - OFS_TIMESTAMP;
      b = stampReg[rel[1:0]*8 +: 8];
    end
    return b;
  endfunction

  // Every request is answered on the next edge; a refusal carries zero data
  always_comb
  begin
    validNext = readReq;
    refusedNext = 1'b0;
    dataNext = BYTE_RESET;
    if (readReq)
    begin
      if (readAddr.recordSet == SET_HEADER && readAddr.byteIndex < HEADER_LEN)
      begin
        dataNext = recordByte(readAddr.byteIndex);
      end
      else if (readAddr.recordSet == SET_FULL && readAddr.byteIndex < RECORD_LEN)
      begin
        dataNext = recordByte(readAddr.byteIndex);
      end
      else
      begin
        refusedNext = 1'b1;
      end
    end
  end

  // Answer registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      validReg <= 1'b0;
      refusedReg <= 1'b0;
      dataReg <= BYTE_RESET;
    end
    else
    begin
      validReg <= validNext;
      refusedReg <= refusedNext;
      dataReg <= dataNext;
    end
  end

  assign readValid = validReg;
  assign readRefused = refusedReg;
  assign readData = dataReg;

endmodule

//--- verilog/iomdr_pkg.sv
package iomdr_pkg;

  // Clock and timer
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int STAMP_WIDTH = 32;

  // Record sets and lengths
  localparam logic [7:0] SET_HEADER = 8'h00;
  localparam logic [7:0] SET_FULL = 8'h01;
  localparam logic [4:0] HEADER_LEN = 5'h04;
  localparam logic [4:0] RECORD_LEN = 5'h14;

  // Byte positions within the record
  localparam logic [4:0] OFS_MODULE_FAULT = 5'h00;
  localparam logic [4:0] OFS_CLASS_INFO = 5'h01;
  localparam logic [4:0] OFS_SPARE_FAULT = 5'h02;
  localparam logic [4:0] OFS_INTERNAL_FAULT = 5'h03;
  localparam logic [4:0] OFS_CHANNEL_KIND = 5'h04;
  localparam logic [4:0] OFS_DIAG_BITS = 5'h05;
  localparam logic [4:0] OFS_CHANNEL_COUNT = 5'h06;
  localparam logic [4:0] OFS_GROUP_SUMMARY = 5'h07;
  localparam logic [4:0] OFS_CHANNEL_FAULT = 5'h08;
  localparam logic [4:0] OFS_UNUSED_FAULT = 5'h0C;
  localparam logic [4:0] OFS_TIMESTAMP = 5'h10;

  // Module fault byte fields
  localparam int MF_FAILURE_BIT = 0;
  localparam int MF_INTERNAL_BIT = 1;
  localparam int MF_EXTERNAL_BIT = 2;
  localparam int MF_CHANNEL_BIT = 3;
  localparam int MF_AUX_SUPPLY_BIT = 4;
  localparam int MF_PARAM_BIT = 7;

  // Internal fault byte fields
  localparam int IF_BUF_OVERFLOW_BIT = 3;
  localparam int IF_COMM_BIT = 4;

  // Per-channel byte fields
  localparam int CF_PARAM_BIT = 0;
  localparam int CF_UNDERFLOW_BIT = 6;
  localparam int CF_OVERFLOW_BIT = 7;

  // Class information
  localparam logic [3:0] CLASS_ANALOG = 4'h5;
  localparam int CLASS_CHAN_INFO_BIT = 4;

  // Channel kind codes
  localparam logic [6:0] KIND_DIGITAL_IN = 7'h70;
  localparam logic [6:0] KIND_ANALOG_IN = 7'h71;
  localparam logic [6:0] KIND_DIGITAL_OUT = 7'h72;
  localparam logic [6:0] KIND_ANALOG_OUT = 7'h73;
  localparam logic [6:0] KIND_ANALOG_INOUT = 7'h74;
  localparam logic [6:0] KIND_COUNTER = 7'h76;

  // Constant descriptor bytes
  localparam logic [7:0] DIAG_BITS_VALUE = 8'h08;
  localparam logic [7:0] CHANNEL_COUNT_VALUE = 8'h04;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Module-level fault conditions
  typedef struct packed {
    logic failure;
    logic internal;
    logic external;
    logic auxSupplyMissing;
    logic paramError;
    logic bufOverflow;
    logic commError;
  } iomdr_module_fault_type;

  // Per-channel fault conditions
  typedef struct packed {
    logic paramError;
    logic underflow;
    logic overflow;
  } iomdr_chan_fault_type;

  // Record read request
  typedef struct packed {
    logic [7:0] recordSet;
    logic [4:0] byteIndex;
  } iomdr_read_req_type;

endpackage

//--- verilog/iomdr_us_timer.sv
`timescale 1ns/1ps
module iomdr_us_timer
  import iomdr_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
)(
  input wire logic core_clk, // Module clock
  input wire logic srst, // Synchronous reset, active high
  output logic [STAMP_WIDTH-1:0] usCount // Free running microsecond count
);

  logic [7:0] divReg;
  logic [7:0] divNext;
  logic [STAMP_WIDTH-1:0] countReg;
  logic [STAMP_WIDTH-1:0] countNext;

  ////////////////////////////////////////////////////////////////////////////
  // Divider gives one tick per microsecond; count wraps by natural overflow
  always_comb
  begin
    divNext = divReg + 8'h01;
    countNext = countReg;
    if (divReg == 8'(TICKS - 1))
    begin
      divNext = 8'h00;
      countNext = countReg + 32'h00000001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      divReg <= 8'h00;
      countReg <= '0;
    end
    else
    begin
      divReg <= divNext;
      countReg <= countNext;
    end
  end

  assign usCount = countReg;

endmodule

//--- tb/iomdr_diag_properties.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Watches the record read port and the indicators
module iomdr_diag_properties
  import iomdr_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int TICKS = TICK_CYCLES
)(
  input wire logic core_clk, // Clock
  input wire logic srst, // Reset
  input wire iomdr_module_fault_type moduleFault, // Module faults
  input wire iomdr_chan_fault_type [NUM_CH-1:0] chanFault, // Channel faults
  input wire logic readReq, // Read strobe
  input wire iomdr_read_req_type readAddr, // Read address
  input wire logic readValid, // Answer strobe
  input wire logic readRefused, // Refusal
  input wire logic [7:0] readData, // Answer byte
  input wire logic [NUM_CH-1:0] chanErrorLed, // Channel indicators
  input wire logic moduleErrorLed // Module indicator
);
  logic [NUM_CH-1:0] anyCh;
  logic [4:0] idx;
  logic full;
  // Per-channel fault summary, the cause of indicator and summary bits
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      anyCh[i] = |chanFault[i];
    end
  end
  // Read decode shorthand
  assign idx = readAddr.byteIndex;
  assign full = readReq && readAddr.recordSet == SET_FULL;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  AST_ANSWER: assert property (readReq |=> readValid)
    else $error("read not answered");
  AST_NO_SPURIOUS: assert property (!readReq |=> !readValid)
    else $error("answer without read");
  AST_KIND: assert property (full && idx == 5'h04 |=> readData == 8'h71 && !readRefused)
    else $error("channel kind wrong");
  AST_DIAG_BITS: assert property (full && idx == 5'h05 |=> readData == 8'h08)
    else $error("diag bit count wrong");
  AST_CHAN_COUNT: assert property (full && idx == 5'h06 |=> readData == 8'h04)
    else $error("channel count wrong");
  AST_CLASS: assert property (full && idx == 5'h01 |=> readData == 8'h15)
    else $error("class byte wrong");
  AST_HEADER_LIMIT: assert property (readReq && readAddr.recordSet == SET_HEADER
    && idx >= 5'h04 |=> readRefused && readData == 8'h00)
    else $error("header set not limited");
  AST_CHAN_LED: assert property (!$past(srst) |-> chanErrorLed == $past(anyCh))
    else $error("channel indicator wrong");
  AST_MODULE_LED: assert property (!$past(srst) |->
    moduleErrorLed == (|$past(moduleFault) || |$past(anyCh)))
    else $error("module indicator wrong");
  AST_SUMMARY: assert property (full && idx == 5'h07 && $stable(chanFault) && !$past(srst)
    |=> readData == {4'h0, $past(anyCh, 2)})
    else $error("group summary wrong");
endmodule

bind iomdr_diag_record iomdr_diag_properties #(.NUM_CH(NUM_CH), .TICKS(TICKS)) uProps (
  .core_clk(core_clk), .srst(srst), .moduleFault(moduleFault), .chanFault(chanFault),
  .readReq(readReq), .readAddr(readAddr), .readValid(readValid),
  .readRefused(readRefused), .readData(readData), .chanErrorLed(chanErrorLed),
  .moduleErrorLed(moduleErrorLed));

//--- tb/iomdr_reader.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Backplane reader: polls the record on request, no interrupt
module iomdr_reader
  import iomdr_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic readValid, // Answer strobe
  input wire logic readRefused, // Refusal
  input wire logic [7:0] readData, // Answer byte
  output logic readReq, // Read strobe
  output iomdr_read_req_type readAddr // Set and byte index
);
  initial
  begin
    readReq = 1'b0;
    readAddr = '0;
  end
  // One strobe, bounded poll; the released address shows its inverse
  task automatic fetch(input logic [7:0] s, input logic [4:0] i, output logic [7:0] d,
    output logic r);
    int n;
    n = 0;
    @(negedge core_clk);
    readReq = 1'b1;
    readAddr = '{s, i};
    @(negedge core_clk);
    readReq = 1'b0;
    readAddr = ~readAddr;
    while (n < 4 && readValid !== 1'b1)
    begin
      @(negedge core_clk);
      n++;
    end
    d = readValid ? readData : 'x;
    r = readValid ? readRefused : 'x;
  endtask
endmodule

//--- tb/test_io_module_diagnostic_record.sv
`timescale 1ns/1ps
module test_io_module_diagnostic_record
  import iomdr_pkg::*;
;
  localparam int TK = 2;
  localparam logic [7:0] IDLE [16] = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h71, 8'h08, 8'h04,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MODB [7] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h80, 8'h00, 8'h00};
  localparam logic [7:0] INTB [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h10};
  localparam logic [7:0] CHB [3] = '{8'h01, 8'h40, 8'h80};
  logic core_clk, srst, readReq, readValid, readRefused, moduleErrorLed;
  iomdr_module_fault_type moduleFault;
  iomdr_chan_fault_type [3:0] chanFault;
  iomdr_read_req_type readAddr;
  logic [7:0] readData;
  logic [3:0] chanErrorLed;
  int errors, tests_run, edgeCnt;
  ////////////////////////////////////////////////////////////
  iomdr_diag_record #(.NUM_CH(4), .TICKS(TK)) DUT (.core_clk(core_clk), .srst(srst),
    .moduleFault(moduleFault), .chanFault(chanFault), .readReq(readReq),
    .readAddr(readAddr), .readValid(readValid), .readRefused(readRefused),
    .readData(readData), .chanErrorLed(chanErrorLed), .moduleErrorLed(moduleErrorLed));
  iomdr_reader rdr (.core_clk(core_clk), .readValid(readValid), .readRefused(readRefused),
    .readData(readData), .readReq(readReq), .readAddr(readAddr));
  // 25 MHz clock and edge count since reset release
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) edgeCnt <= srst ? 0 : edgeCnt + 1;
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] s, input logic [4:0] i, input logic [7:0] e,
    input logic er);
    logic [7:0] d;
    logic r;
    rdr.fetch(s, i, d, r);
    check(d, e);
    check({7'h00, r}, {7'h00, er});
  endtask
  task automatic conclude();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Fault-free record, header set and refused places
  task automatic t_idle();
    for (int i = 0; i < 16; i++) rd(SET_FULL, i[4:0], IDLE[i], 1'b0);
    for (int i = 0; i < 4; i++) rd(SET_HEADER, i[4:0], IDLE[i], 1'b0);
    rd(SET_HEADER, 5'h04, 8'h00, 1'b1);
    rd(SET_FULL, 5'h14, 8'h00, 1'b1);
    rd(8'h02, 5'h00, 8'h00, 1'b1);
  endtask
  // Each module fault alone, then cleared: bytes are live
  task automatic t_module();
    for (int b = 0; b < 7; b++)
    begin
      @(negedge core_clk);
      moduleFault = 7'h40 >> b;
      rd(SET_FULL, 5'h00, MODB[b], 1'b0);
      rd(SET_FULL, 5'h03, INTB[b], 1'b0);
      check({7'h00, moduleErrorLed}, 8'h01);
      moduleFault = '0;
      rd(SET_FULL, 5'h00, 8'h00, 1'b0);
    end
  endtask
  // Each channel with each fault kind
  task automatic t_channel();
    for (int c = 0; c < 4; c++)
      for (int f = 0; f < 3; f++)
      begin
        @(negedge core_clk);
        chanFault = '0;
        chanFault[c] = 3'h4 >> f;
        rd(SET_FULL, 5'h08 + c[4:0], CHB[f], 1'b0);
        rd(SET_FULL, 5'h07, 8'h01 << c, 1'b0);
        rd(SET_FULL, 5'h00, 8'h08, 1'b0);
        check({4'h0, chanErrorLed}, 8'h01 << c);
      end
    chanFault = '0;
  endtask
  // Raise a fault on a tick-aligned edge and read the stamp back
  task automatic stamp(input bit redo);
    logic [31:0] e;
    for (int n = 0; n < 4 && edgeCnt % TK != 0; n++) @(negedge core_clk);
    check(8'(edgeCnt % TK), 8'h00);
    e = edgeCnt / TK;
    moduleFault.failure = 1'b1;
    for (int i = 0; i < 4; i++) rd(SET_FULL, 5'h10 + i[4:0], e[8*i+:8], 1'b0);
    moduleFault = '0;
    repeat (9) @(negedge core_clk);
    if (redo)
      for (int i = 0; i < 4; i++) rd(SET_FULL, 5'h10 + i[4:0], e[8*i+:8], 1'b0);
  endtask
  task automatic t_timer();
    srst = 1'b1;
    repeat (12) @(negedge core_clk);
    srst = 1'b0;
    repeat (20) @(negedge core_clk);
    stamp(1'b1);
    repeat (301) @(negedge core_clk);
    stamp(1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence and hang guard
  initial
  begin
    errors = 0;
    tests_run = 0;
    srst = 1'b1;
    moduleFault = '0;
    chanFault = '0;
    repeat (12) @(negedge core_clk);
    srst = 1'b0;
    t_idle();
    t_module();
    t_channel();
    t_timer();
    conclude();
  end
  initial
  begin
    repeat (50000) @(posedge core_clk);
    errors++;
    conclude();
  end
endmodule
